// >>> rts_reset_sequencer.sv
// Reset and start-up time-out sequencer with Avalon-MM register access

// Summary of operation
// - Record seven distinct reset and wake causes
// - Scratch register never reset by anything
// - Reset events pulse register initialise request
// - Watchdog wake resumes without register initialise
// - Expired and sleep flags set per cause; a pin reset in run leaves them
// - Reset pin glitches are filtered away
// - Watchdog reset never drives the pin
// - Supply rise alone makes the power-on reset
// - Power-up delay 72 ms, power-on or undervoltage
// - Delay paced by RC tick; core held
// - Config bit skips the power-up delay
// - Count 1024 oscillator edges after delay
// - Oscillator count only in crystal modes
// - Undervoltage must last 100 us to reset
// - Undervoltage holds until recovery, then delay
// - New drop during delay restarts sequence
// - Undervoltage enable forces the delay on
// - Order: delay, oscillator count, then release
// - Late pin release starts execution at once
// - Select 11 RC, 10 HS, 01 XT, 00 LP
// - Power-on and undervoltage status flags cleared
// - Flag values per cause as encoded
module rts_reset_sequencer
  import rts_pkg::*;
#(
  parameter int POWER_UP_DELAY_TIMER_TICKS_P  = POWER_UP_DELAY_TIMER_TICKS,     // Shorten for simulation
  parameter int UV_QUAL_CYC_P = UV_QUAL_CYC,    // Shorten for simulation
  parameter int OST_CYCLES_P  = OST_CYCLES,
  parameter int FILTER_CYC_P  = PIN_FILTER_CYC
) (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // Analog detectors and pins
  input  wire logic       supplyUp,             // Supply-rise detector, high when supply is up
  input  wire logic       undervoltLow,         // Supply below undervoltage threshold
  input  wire logic       externalResetPin_n,   // Reset pin level
  output logic            externalResetPinOut,  // Pin driver data, never low-driven
  output logic            externalResetPinOe,   // Pin driver enable, never on
  input  wire logic       oscillatorInputPin,   // Oscillator input, sampled
  // Core side
  input  wire logic       watchdogTimeout,      // Watchdog expiry pulse
  input  wire logic       coreSleeping,         // Core is in sleep
  input  wire logic       irqWake,              // Interrupt wake request pulse
  input  wire logic       sleepCmd,             // Core executes sleep
  input  wire logic       watchdogClearCmd,     // Core clears the watchdog
  output logic            coreReset_n,          // Core reset, active low
  output logic            coreStall,            // Core clock held during wake start-up
  output logic            regInit,              // Load reset values, one-cycle pulse
  output logic            wakeResume,           // Resume after wake, one-cycle pulse
  output logic [2:0]      resetCause,           // Last recorded cause
  // Avalon-MM slave
  input  wire logic [3:0] avs_address,
  input  wire logic       avs_read,
  input  wire logic       avs_write,
  input  wire logic [3:0] avs_byteenable,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]     avs_readdata,
  output logic            avs_waitrequest
);

  localparam int PW = $clog2(POWER_UP_DELAY_TIMER_TICKS_P + 1);
  localparam int UW = $clog2(UV_QUAL_CYC_P + 1);
  localparam int OW = $clog2(OST_CYCLES_P + 1);
  localparam int FW = $clog2(FILTER_CYC_P + 1);
  localparam int DW = $clog2(RC_TICK_CYC + 1);

  logic          rstMeta;         // First reset release stage
  logic          rstSyncN;        // Released reset for the whole block except the scratch register
  logic [2:0]    syncA;           // First input sync stage, read only by syncB
  logic [2:0]    syncB;           // Synchronised detector and pin levels
  logic          supplyUpD;       // Delayed supply level for edge detect
  logic          oscD;            // Sampled oscillator input
  logic          oscD2;           // Delayed oscillator sample
  logic [FW-1:0] pinCnt;          // Pin filter counter
  logic          pinFilt;         // Filtered pin low
  logic          pinFiltD;        // Delayed filtered pin
  logic [UW-1:0] uvCnt;           // Undervoltage qualify counter
  logic          uvHeld;          // Qualified undervoltage in force
  logic [DW-1:0] rcDiv;           // RC time base divider
  logic          rcTick;          // RC tick enable
  logic [PW-1:0] pwrtCnt;         // Power-up delay counter
  logic [OW-1:0] ostCnt;          // Oscillator edge counter
  rts_state_t    state;           // Sequencer state
  rts_cause_t    cause;           // Recorded cause
  logic          seqDelay;        // Current sequence wants delay stages
  logic          wakeMode;        // Current sequence is a wake from sleep
  logic [7:0]    config_q;        // Config register
  logic [7:0]    scratch;         // Never-initialised register
  logic          watchdogExpired; // Watchdog expired flag
  logic          sleepEntered;    // Sleep entered flag
  logic          powerOnStatus;   // Power-on status flag
  logic          uvStatus;        // Undervoltage status flag
  logic          accDone;         // Bus answer phase

  logic pinLowS, uvLow, porEvt, uvTrip, pinFiltRise, crystal, pwrtOn, pwrtDone, ostDone, oscRise;
  logic evPor, evUv, evPin, evWdtRst, evWdtWake, evIrqWake, busReq, busWr;
  rts_osc_t clkSel;

  // Reset release through two flops
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta  <= 1'b0;
      rstSyncN <= 1'b0;
    end else begin
      rstMeta  <= 1'b1;
      rstSyncN <= rstMeta;
    end
  end

  // Two-flop synchronisers for pin and detectors
  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      syncA <= 3'h3;
      syncB <= 3'h3;
    end else begin
      syncA <= {undervoltLow, supplyUp, externalResetPin_n};
      syncB <= syncA;
    end
  end

  // Decoded input levels and config fields
  assign pinLowS = !syncB[0];
  assign clkSel  = rts_osc_t'(config_q[CFG_SEL_LSB +: 2]);
  assign crystal = (clkSel != OSC_RC);
  assign pwrtOn  = !config_q[CFG_POWER_UP_DELAY_TIMER_DIS] || config_q[CFG_UV_EN];
  assign uvLow   = config_q[CFG_UV_EN] && syncB[2];

  // Edge detectors for supply and oscillator
  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      supplyUpD <= 1'b1;
      oscD      <= 1'b0;
      oscD2     <= 1'b0;
      pinFiltD  <= 1'b0;
    end else begin
      supplyUpD <= syncB[1];
      oscD      <= oscillatorInputPin;
      oscD2     <= oscD;
      pinFiltD  <= pinFilt;
    end
  end
  assign porEvt      = syncB[1] && !supplyUpD;
  assign oscRise     = oscD && !oscD2;
  assign pinFiltRise = pinFilt && !pinFiltD;

  // Pin filter: level must stand for the filter length
  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      pinCnt  <= '0;
      pinFilt <= 1'b0;
    end else if (pinLowS == pinFilt) begin
      pinCnt  <= '0;                              // Short pulse forgotten
    end else if (pinCnt == FW'(FILTER_CYC_P - 1)) begin
      pinCnt  <= '0;
      pinFilt <= pinLowS;
    end else begin
      pinCnt  <= pinCnt + 1'b1;
    end
  end

  // Undervoltage qualify and hold
  assign uvTrip = uvLow && !uvHeld && (uvCnt == UW'(UV_QUAL_CYC_P - 1));
  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      uvCnt  <= '0;
      uvHeld <= 1'b0;
    end else if (!uvLow) begin
      uvCnt  <= '0;
      uvHeld <= 1'b0;
    end else begin
      if (uvCnt != UW'(UV_QUAL_CYC_P - 1)) begin
        uvCnt <= uvCnt + 1'b1;
      end
      if (uvTrip) begin
        uvHeld <= 1'b1;
      end
    end
  end

  // RC time base; free-running so ticks stand apart from the sequence start
  assign rcTick = (rcDiv == DW'(RC_TICK_CYC - 1));
  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      rcDiv <= '0;
    end else begin
      rcDiv <= rcTick ? '0 : rcDiv + 1'b1;
    end
  end

  // Event decode in priority order
  always_comb begin
    evPor     = porEvt;
    evUv      = !porEvt && uvTrip;
    evPin     = !porEvt && !uvTrip && pinFiltRise && (state == ST_RUN || wakeMode);
    evWdtRst  = !porEvt && !uvTrip && !evPin && watchdogTimeout && state == ST_RUN && !coreSleeping;
    evWdtWake = !porEvt && !uvTrip && !evPin && watchdogTimeout && state == ST_RUN && coreSleeping;
    evIrqWake = !porEvt && !uvTrip && !evPin && !watchdogTimeout && irqWake && state == ST_RUN && coreSleeping;
  end

  // Stage counters
  assign pwrtDone = rcTick && (pwrtCnt == PW'(POWER_UP_DELAY_TIMER_TICKS_P - 1));
  assign ostDone  = oscRise && (ostCnt == OW'(OST_CYCLES_P - 1));
  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      pwrtCnt <= '0;
      ostCnt  <= '0;
    end else begin
      pwrtCnt <= (state != ST_POWER_UP_DELAY_TIMER) ? '0 : (rcTick ? pwrtCnt + 1'b1 : pwrtCnt);
      ostCnt  <= (state != ST_OST) ? '0 : (oscRise ? ostCnt + 1'b1 : ostCnt);
    end
  end

  // Sequencer
  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      state    <= ST_HOLD;
      cause    <= CAUSE_POR;
      seqDelay <= 1'b1;
      wakeMode <= 1'b0;
    end else if (evPor || evUv) begin
      state    <= ST_HOLD;
      cause    <= evPor ? CAUSE_POR : CAUSE_BOR;
      seqDelay <= 1'b1;
      wakeMode <= 1'b0;
    end else if (evPin || evWdtRst) begin
      state    <= ST_HOLD;
      cause    <= evWdtRst ? CAUSE_WDT_RST : (coreSleeping || wakeMode) ? CAUSE_PIN_SLEEP : CAUSE_PIN_RUN;
      seqDelay <= 1'b0;
      wakeMode <= 1'b0;
    end else if (evWdtWake || evIrqWake) begin
      state    <= crystal ? ST_OST : ST_RUN;
      cause    <= evWdtWake ? CAUSE_WDT_WAKE : CAUSE_IRQ_WAKE;
      wakeMode <= crystal;
    end else begin
      unique case (state)
        ST_HOLD: begin
          // Wait for the supply to stand before timing
          if (!uvHeld && syncB[1]) begin
            if (seqDelay && pwrtOn) begin
              state <= ST_POWER_UP_DELAY_TIMER;
            end else if (seqDelay && crystal) begin
              state <= ST_OST;
            end else begin
              state <= ST_RUN;
            end
          end
        end
        ST_POWER_UP_DELAY_TIMER: begin
          if (pwrtDone) begin
            state <= crystal ? ST_OST : ST_RUN;
          end
        end
        ST_OST: begin
          if (ostDone) begin
            state    <= ST_RUN;
            wakeMode <= 1'b0;
          end
        end
        ST_RUN: begin
          state <= ST_RUN;
        end
      endcase
    end
  end

  // Core-facing outputs, registered
  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      coreReset_n <= 1'b0;
      coreStall   <= 1'b0;
      regInit     <= 1'b0;
      wakeResume  <= 1'b0;
    end else begin
      // Release only when every source has gone and every stage has ended
      coreReset_n <= !((state != ST_RUN && !wakeMode) || pinFilt || uvHeld || !syncB[1]);
      coreStall   <= wakeMode && state == ST_OST;
      regInit     <= evPor || evUv || evPin || evWdtRst;
      wakeResume  <= ((evWdtWake || evIrqWake) && !crystal) || (state == ST_OST && ostDone && wakeMode);
    end
  end
  assign resetCause          = cause;
  assign externalResetPinOut = 1'b0;
  assign externalResetPinOe  = 1'b0;

  // Avalon-MM: one wait cycle, answer on the second edge
  assign busReq          = avs_read || avs_write;
  assign busWr           = avs_write && accDone;
  assign avs_waitrequest = busReq && !accDone;
  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      accDone      <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      accDone <= busReq && !accDone;
      if (avs_read && !accDone) begin
        unique case (avs_address & 4'hc)
          ADDR_CONFIG:  avs_readdata <= {24'h00_0000, config_q};
          ADDR_STATUS:  avs_readdata <= {24'h00_0000, !coreReset_n, cause, sleepEntered,
                                         watchdogExpired, powerOnStatus, uvStatus};
          ADDR_SCRATCH: avs_readdata <= {24'h00_0000, scratch};
          default:      avs_readdata <= 32'h0000_0000;   // Unmapped reads as zero
        endcase
      end
    end
  end

  // Config register
  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      config_q <= CONFIG_RESET;
    end else if (busWr && avs_byteenable[0] && (avs_address & 4'hc) == ADDR_CONFIG) begin
      config_q <= avs_writedata[7:0];
    end
  end

  // Scratch storage: no reset term at all
  always_ff @(posedge core_clk) begin
    if (busWr && avs_byteenable[0] && (avs_address & 4'hc) == ADDR_SCRATCH) begin
      scratch <= avs_writedata[7:0];
    end
  end

  // Status flags: a hardware event beats a software write in the same cycle
  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      watchdogExpired <= 1'b1;
      sleepEntered    <= 1'b1;
      powerOnStatus   <= 1'b0;
      uvStatus        <= 1'b0;
    end else begin
      if (evPor || evUv || (evPin && (coreSleeping || wakeMode)) || evIrqWake) begin
        watchdogExpired <= 1'b1;
        sleepEntered    <= !(evPin || evIrqWake);
      end else if (evWdtRst || evWdtWake) begin
        watchdogExpired <= 1'b0;
        sleepEntered    <= evWdtRst;
      end else if (sleepCmd) begin
        watchdogExpired <= 1'b1;
        sleepEntered    <= 1'b0;
      end else if (watchdogClearCmd) begin
        watchdogExpired <= 1'b1;
        sleepEntered    <= 1'b1;
      end
      if (evPor) begin
        powerOnStatus <= 1'b0;
      end else if (busWr && avs_byteenable[0] && (avs_address & 4'hc) == ADDR_STATUS) begin
        powerOnStatus <= avs_writedata[ST_POR_BIT];
      end
      if (evUv) begin
        uvStatus <= 1'b0;
      end else if (busWr && avs_byteenable[0] && (avs_address & 4'hc) == ADDR_STATUS) begin
        uvStatus <= avs_writedata[ST_UV_BIT];
      end
    end
  end

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstSyncN);

  sequence s_wdt_wake;
    evWdtWake;
  endsequence

  sequence s_wake_quiet;
    !regInit && !watchdogExpired && !sleepEntered;
  endsequence

  a_pin_filter_len: assert property ($rose(pinFilt) |-> $past(pinLowS, 1) && $past(pinLowS, FILTER_CYC_P))
    else $error("pin accepted without a stable low");
  a_wdt_pin_quiet: assert property (evWdtRst |-> ##1 (!externalResetPinOe && regInit))
    else $error("watchdog reset drove the pin or skipped init");
  a_por_holds_core: assert property (evPor |-> ##2 !coreReset_n)
    else $error("power-on event did not hold the core");
  a_power_up_delay_timer_keeps_on: assert property ((state == ST_POWER_UP_DELAY_TIMER && !pwrtDone && !porEvt && !uvTrip) |=> state == ST_POWER_UP_DELAY_TIMER)
    else $error("power-up delay left early");
  a_power_up_delay_timer_core_rst: assert property (state == ST_POWER_UP_DELAY_TIMER |=> !coreReset_n)
    else $error("core released during power-up delay");
  a_power_up_delay_timer_enable_ok: assert property ($rose(state == ST_POWER_UP_DELAY_TIMER) |-> $past(pwrtOn))
    else $error("power-up delay ran while disabled");
  a_ost_crystal: assert property (state == ST_OST |-> crystal)
    else $error("oscillator count ran in RC mode");
  a_ost_keeps_on: assert property ((state == ST_OST && !ostDone && !porEvt && !uvTrip && !evPin) |=> state == ST_OST)
    else $error("oscillator count left early");
  a_uv_qualified: assert property ($rose(uvHeld) |-> $past(uvLow, 1) && $past(uvLow, 2))
    else $error("undervoltage reset without qualify time");
  a_uv_hold_core: assert property (uvHeld |-> ##1 !coreReset_n)
    else $error("core released while undervoltage held");
  a_uv_restart: assert property ((state == ST_POWER_UP_DELAY_TIMER && evUv) |=> (state == ST_HOLD && cause == CAUSE_BOR))
    else $error("undervoltage during delay did not restart");
  a_wake_no_init: assert property (s_wdt_wake |=> s_wake_quiet)
    else $error("watchdog wake initialised registers or flags wrong");
  a_por_flags: assert property (evPor |=> watchdogExpired && sleepEntered && !powerOnStatus)
    else $error("power-on flags wrong");
  a_release_clean: assert property ($rose(coreReset_n) |-> $past(state == ST_RUN && !pinFilt && !uvHeld))
    else $error("core released with a source active");

endmodule // rts_reset_sequencer

// >>> rts_pkg.sv
// Constants, field layouts and types shared by the reset and time-out sequencer
package rts_pkg;

  // Core clock
  localparam int CLK_PERIOD_NS   = 10;                                        // 100 MHz core clock

  // Internal RC time base that paces the power-up delay
  localparam int RC_TICK_NS      = 1000;                                      // One RC tick per microsecond
  localparam int RC_TICK_CYC     = RC_TICK_NS / CLK_PERIOD_NS;                // Core cycles per RC tick

  // Power-up delay, in its own unit and as RC ticks
  localparam int POWER_UP_DELAY_TIMER_TIME_MS    = 72;                                        // Nominal power-up delay
  localparam int POWER_UP_DELAY_TIMER_TICKS      = POWER_UP_DELAY_TIMER_TIME_MS * 1000000 / RC_TICK_NS;       // Ticks of the RC time base

  // Undervoltage qualify time; a least time, so rounded up
  localparam int UV_QUAL_TIME_US = 100;                                       // Low supply must last this long
  localparam int UV_QUAL_CYC     = (UV_QUAL_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Oscillator start-up count and pin filter length
  localparam int OST_CYCLES      = 1024;                                      // Oscillator input edges to wait
  localparam int PIN_FILTER_CYC  = 4;                                         // Stable cycles to accept a pin level

  // Register byte offsets
  localparam logic [3:0] ADDR_CONFIG  = 4'h0;                                 // Clock mode and delay enables
  localparam logic [3:0] ADDR_STATUS  = 4'h4;                                 // Flags, cause and reset state
  localparam logic [3:0] ADDR_SCRATCH = 4'h8;                                 // Never-initialised storage

  // Reset values
  localparam logic [7:0] CONFIG_RESET = 8'h03;                                // RC mode, delay on, undervoltage off

  // Config field positions
  localparam int CFG_SEL_LSB     = 0;                                         // Clock source select, 2 bits
  localparam int CFG_POWER_UP_DELAY_TIMER_DIS    = 2;                                         // Power-up delay enable, active low
  localparam int CFG_UV_EN       = 3;                                         // Undervoltage detect enable

  // Status field positions
  localparam int ST_UV_BIT       = 0;                                         // Undervoltage status flag
  localparam int ST_POR_BIT      = 1;                                         // Power-on status flag
  localparam int ST_TO_BIT       = 2;                                         // Watchdog expired flag
  localparam int ST_PD_BIT       = 3;                                         // Sleep entered flag
  localparam int ST_CAUSE_LSB    = 4;                                         // Last cause, 3 bits
  localparam int ST_INRST_BIT    = 7;                                         // Core held in reset

  // Oscillator modes, encoded as the clock source select bits
  typedef enum logic [1:0] {
    OSC_LP = 2'h0,
    OSC_XT = 2'h1,
    OSC_HS = 2'h2,
    OSC_RC = 2'h3
  } rts_osc_t;

  // Last recorded reset or wake cause
  typedef enum logic [2:0] {
    CAUSE_NONE,
    CAUSE_POR,
    CAUSE_PIN_RUN,
    CAUSE_PIN_SLEEP,
    CAUSE_WDT_RST,
    CAUSE_WDT_WAKE,
    CAUSE_BOR,
    CAUSE_IRQ_WAKE
  } rts_cause_t;

  // Sequencer states
  typedef enum logic [1:0] {
    ST_RUN,
    ST_HOLD,
    ST_POWER_UP_DELAY_TIMER,
    ST_OST
  } rts_state_t;

endpackage

// >>> rts_reset_sequencer_tb.sv
// Self-checking bench for the reset and time-out sequencer
module rts_reset_sequencer_tb
  import rts_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk, rst_n, supplyUp, undervoltLow, externalResetPin_n, oscillatorInputPin;
  logic        watchdogTimeout, coreSleeping, irqWake, sleepCmd, watchdogClearCmd;
  logic        externalResetPinOut, externalResetPinOe, coreReset_n, coreStall, regInit, wakeResume;
  logic [2:0]  resetCause;
  logic [3:0]  avs_address, avs_byteenable;
  logic        avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata, rd, scr;
  logic [16:0] lfsr;                            // Stimulus generator state
  int          fail_count, samples_checked, cyc, inits, resumes, snap, pinDriven;

  // Short counts keep the run brief
  rts_reset_sequencer #(.POWER_UP_DELAY_TIMER_TICKS_P(5), .UV_QUAL_CYC_P(8), .OST_CYCLES_P(4), .FILTER_CYC_P(4)) i_rts_reset_sequencer (
    .core_clk(core_clk), .rst_n(rst_n), .supplyUp(supplyUp), .undervoltLow(undervoltLow),
    .externalResetPin_n(externalResetPin_n), .externalResetPinOut(externalResetPinOut),
    .externalResetPinOe(externalResetPinOe), .oscillatorInputPin(oscillatorInputPin),
    .watchdogTimeout(watchdogTimeout), .coreSleeping(coreSleeping), .irqWake(irqWake), .sleepCmd(sleepCmd),
    .watchdogClearCmd(watchdogClearCmd), .coreReset_n(coreReset_n), .coreStall(coreStall), .regInit(regInit),
    .wakeResume(wakeResume), .resetCause(resetCause), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

  // Clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Oscillator input rises every second cycle; event monitors; hang guard
  always @(posedge core_clk) begin
    oscillatorInputPin <= ~oscillatorInputPin;
    cyc++;
    if (regInit === 1'b1) inits++;
    if (wakeResume === 1'b1) resumes++;
    if (externalResetPinOe !== 1'b0) pinDriven++;
    if (cyc == 30000) begin
      fail_count++;
      close_out();
    end
  end

  // Next stimulus value
  function automatic logic [16:0] lfsr_next(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction

  // Expected status byte from flags and cause
  function automatic logic [31:0] st(input logic [2:0] c, input logic to, pd, por, uv);
    return {24'h0, 1'b0, c, pd, to, por, uv};
  endfunction

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One Avalon access; request held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
    int n;
    logic ok;
    n = 0;
    ok = 1'b0;
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= d;
    avs_byteenable <= be;
    // Settled waitrequest mid-cycle is what the next rising edge samples
    do begin
      @(negedge core_clk);
      ok = (avs_waitrequest === 1'b0);
      @(posedge core_clk);
      n++;
    end while (!ok && n < 50);
    if (!ok) fail_count++;
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask

  // Bounded wait for a core reset level, then compare
  task automatic wait_core(input logic v, input int lim);
    int n;
    n = 0;
    while (coreReset_n !== v && n < lim) begin
      @(posedge core_clk);
      n++;
    end
    chk({31'h0, coreReset_n}, {31'h0, v});
  endtask

  // Drive one pin input: 0 pin, 1 watchdog, 2 sleep, 3 undervoltage, 4 supply
  task automatic put(input int k, input logic v);
    case (k)
      0: externalResetPin_n <= v;
      1: watchdogTimeout <= v;
      2: sleepCmd <= v;
      3: undervoltLow <= v;
      default: supplyUp <= v;
    endcase
  endtask

  // Pulse helper, scaled by repeat count
  task automatic hold(input int k, input logic v, input int n);
    put(k, v);
    repeat (n) @(posedge core_clk);
    put(k, ~v);
    @(posedge core_clk);
  endtask

  // Verdict
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    {rst_n, undervoltLow, watchdogTimeout, coreSleeping, irqWake, sleepCmd, watchdogClearCmd} = '0;
    {avs_read, avs_write, oscillatorInputPin} = '0;
    {avs_address, avs_byteenable, avs_writedata} = '0;
    {supplyUp, externalResetPin_n} = 2'b11;
    lfsr = 17'h12e4b;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (400) @(posedge core_clk);
    chk({31'h0, coreReset_n}, 32'h0);
    wait_core(1'b1, 300);
    bus(1'b0, ADDR_CONFIG, 32'h0, 4'hf); chk(rd, 32'h03);
    bus(1'b0, ADDR_STATUS, 32'h0, 4'hf); chk(rd, st(3'h1, 1'b1, 1'b1, 1'b0, 1'b0));
    bus(1'b0, 4'hc, 32'h0, 4'hf); chk(rd, 32'h0);
    lfsr = lfsr_next(lfsr);
    scr = {24'h0, lfsr[7:0]};
    bus(1'b1, ADDR_SCRATCH, scr, 4'hf);
    bus(1'b1, ADDR_CONFIG, 32'h01, 4'h0);
    bus(1'b0, ADDR_CONFIG, 32'h0, 4'hf); chk(rd, 32'h03);
    bus(1'b1, ADDR_CONFIG, 32'h01, 4'hf);
    bus(1'b1, ADDR_STATUS, 32'h03, 4'hf);
    // Glitch shorter than the filter, then a real pin reset
    lfsr = lfsr_next(lfsr);
    hold(0, 1'b0, 1 + lfsr[1:0] % 3);
    repeat (10) @(posedge core_clk);
    chk({31'h0, coreReset_n}, 32'h1);
    snap = inits;
    hold(0, 1'b0, 12);
    wait_core(1'b1, 30);
    chk(inits - snap, 32'h1);
    bus(1'b0, ADDR_STATUS, 32'h0, 4'hf); chk(rd, st(3'h2, 1'b1, 1'b1, 1'b1, 1'b1));
    bus(1'b0, ADDR_SCRATCH, 32'h0, 4'hf); chk(rd, scr);
    // Watchdog reset in run
    hold(1, 1'b1, 1);
    wait_core(1'b0, 10);
    wait_core(1'b1, 30);
    bus(1'b0, ADDR_STATUS, 32'h0, 4'hf); chk(rd, st(3'h4, 1'b0, 1'b1, 1'b1, 1'b1));
    chk(pinDriven, 32'h0);
    // Watchdog wake from sleep in crystal mode
    snap = inits;
    hold(2, 1'b1, 1);
    coreSleeping <= 1'b1;
    hold(1, 1'b1, 1);
    repeat (2) @(posedge core_clk);
    chk({31'h0, coreStall}, 32'h1);
    for (int n = 0; n < 40 && resumes == 0; n++) @(posedge core_clk);
    chk(resumes, 32'h1);
    coreSleeping <= 1'b0;
    chk(inits - snap, 32'h0);
    bus(1'b0, ADDR_STATUS, 32'h0, 4'hf); chk(rd, st(3'h5, 1'b0, 1'b0, 1'b1, 1'b1));
    // Undervoltage: short dip, long dip, dip again during the delay
    bus(1'b1, ADDR_CONFIG, 32'h0d, 4'hf);
    hold(3, 1'b1, 4);
    repeat (10) @(posedge core_clk);
    chk({31'h0, coreReset_n}, 32'h1);
    hold(3, 1'b1, 20);
    repeat (300) @(posedge core_clk);
    chk({31'h0, coreReset_n}, 32'h0);
    hold(3, 1'b1, 20);
    repeat (400) @(posedge core_clk);
    chk({31'h0, coreReset_n}, 32'h0);
    wait_core(1'b1, 300);
    bus(1'b0, ADDR_STATUS, 32'h0, 4'hf); chk(rd, st(3'h6, 1'b1, 1'b1, 1'b1, 1'b0));
    // Power cycle with the pin held past all delays
    bus(1'b1, ADDR_CONFIG, 32'h01, 4'hf);
    externalResetPin_n <= 1'b0;
    hold(4, 1'b0, 10);
    repeat (1200) @(posedge core_clk);
    chk({31'h0, coreReset_n}, 32'h0);
    externalResetPin_n <= 1'b1;
    wait_core(1'b1, 12);
    bus(1'b0, ADDR_STATUS, 32'h0, 4'hf); chk(rd, st(3'h1, 1'b1, 1'b1, 1'b0, 1'b0));
    close_out();
  end
endmodule // rts_reset_sequencer_tb
